// file: core/macrocell_pkg.sv
// Constants, register map and mode type for the output macrocell array
package macrocell_pkg;
  localparam int CELLS = 8;
  localparam int TERMS_PER_CELL = 8;
  localparam int TERMS = 64;
  localparam int DED_INPUTS = 11;
  localparam int ARRAY_INPUTS = 19;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_ARCH = 12'h000;
  localparam logic [11:0] ADDR_CELL_CFG = 12'h004;
  localparam logic [11:0] ADDR_TERM_EN_LO = 12'h008;
  localparam logic [11:0] ADDR_TERM_EN_HI = 12'h00c;
  localparam logic [11:0] ADDR_SIG_LO = 12'h010;
  localparam logic [11:0] ADDR_SIG_HI = 12'h014;
  localparam logic [11:0] ADDR_PRELOAD = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_TERM_BASE = 12'h100;
  localparam logic [11:0] ADDR_TERM_SPAN = 12'h200;
  localparam int ARCH_SYNC_BIT = 0;
  localparam int ARCH_CTRL_BIT = 1;
  localparam int CFG_ROLE_LSB = 8;
  localparam int STATUS_PD_BIT = 8;
  localparam int STATUS_MODE_LSB = 9;
  localparam logic ARCH_SYNC_RESET = 1'b1;
  localparam logic ARCH_CTRL_RESET = 1'b0;
  localparam logic [31:0] TERM_EN_RESET = 32'hffffffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int INNER_CELL_A = 3;
  localparam int INNER_CELL_B = 4;
  localparam int OUTER_CELL_OE = 0;
  localparam int OUTER_CELL_CLK = 7;
  typedef enum logic [1:0] {MODE_SIMPLE, MODE_COMPLEX, MODE_REGISTERED} mode_t;
endpackage

// file: core/output_macrocell_array.sv
// Eight configurable output macrocells with an AXI4-Lite configuration port
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module output_macrocell_array
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [10:0] data_in,
  input wire logic clk_or_in_pin,
  input wire logic oe_n_or_in_pin,
  input wire logic powerdown_pin,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [7:0] io_oe
);

  typedef struct packed {
    logic sync_mode_bit;
    logic global_mode_ctrl_bit;
    logic [7:0] polarity;
    logic [7:0] cell_role_select_bit;
    logic [63:0] term_en;
    logic [63:0] user_signature_area;
    logic [63:0][18:0] mask_true;
    logic [63:0][18:0] mask_comp;
    logic [7:0] cell_q;
    logic [10:0] in_s;
    logic [7:0] io_s;
    logic clk_s;
    logic clk_prev;
    logic oe_n_s;
    logic pd_s;
    logic [7:0] out;
    logic [7:0] oe;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t ST_RESET = '{
    sync_mode_bit: macrocell_pkg::ARCH_SYNC_RESET,
    global_mode_ctrl_bit: macrocell_pkg::ARCH_CTRL_RESET,
    term_en: {macrocell_pkg::TERM_EN_RESET, macrocell_pkg::TERM_EN_RESET},
    default: '0
  };

  state_t st;
  state_t next_st;
  macrocell_pkg::mode_t mode;
  logic [18:0] array_vec;
  logic [63:0] pterm;
  logic [7:0] slot;
  logic [7:0] sum_full;
  logic [7:0] sum_io;
  logic [7:0] oe_term;
  logic clk_rise;
  logic aw_go;
  logic w_go;
  logic ar_go;
  logic [11:0] toff_w;
  logic [11:0] toff_r;

  // Two global bits pick the mode for all cells; the unused 00 code falls back to simple
  function automatic macrocell_pkg::mode_t mode_of(input logic sync_b, input logic ctrl_b);
    if (!sync_b && ctrl_b)
    begin
      return macrocell_pkg::MODE_REGISTERED;
    end
    else if (sync_b && ctrl_b)
    begin
      return macrocell_pkg::MODE_COMPLEX;
    end
    return macrocell_pkg::MODE_SIMPLE;
  endfunction

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address falls inside the product-term mask window
  function automatic logic in_terms(input logic [11:0] a);
    return (a >= macrocell_pkg::ADDR_TERM_BASE) &&
           (a < macrocell_pkg::ADDR_TERM_BASE + macrocell_pkg::ADDR_TERM_SPAN);
  endfunction

  assign mode = mode_of(st.sync_mode_bit, st.global_mode_ctrl_bit);
  assign clk_rise = st.clk_s && !st.clk_prev;
  assign toff_w = st.aw_addr - macrocell_pkg::ADDR_TERM_BASE;
  assign toff_r = s_axi_araddr - macrocell_pkg::ADDR_TERM_BASE;

  // Handshake outputs; a pending response blocks new requests so one write and one read are in flight
  assign s_axi_awready = ce && !st.aw_held && !st.bvalid;
  assign s_axi_wready = ce && !st.w_held && !st.bvalid;
  assign s_axi_arready = ce && !st.rvalid;
  assign aw_go = s_axi_awvalid && s_axi_awready;
  assign w_go = s_axi_wvalid && s_axi_wready;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign io_out = st.out;
  assign io_oe = st.oe;

  // Feedback slot per cell; the power-down pin never reaches the array
  generate
    for (genvar i = 0; i < macrocell_pkg::CELLS; i++)
    begin : g_slot
      // Simple-mode source: the next pin outward, so the two inner pins never feed back
      localparam int NEIGHBOUR = (i < macrocell_pkg::CELLS / 2) ? ((i > 0) ? i - 1 : i) :
                                 ((i < macrocell_pkg::CELLS - 1) ? i + 1 : i);
      always_comb
      begin
        case (mode)
          macrocell_pkg::MODE_REGISTERED:
          begin
            slot[i] = st.cell_role_select_bit[i] ? st.io_s[i] : st.cell_q[i];
          end
          macrocell_pkg::MODE_COMPLEX:
          begin
            if (i == macrocell_pkg::OUTER_CELL_OE)
            begin
              slot[i] = st.oe_n_s;
            end
            else if (i == macrocell_pkg::OUTER_CELL_CLK)
            begin
              slot[i] = st.clk_s;
            end
            else
            begin
              slot[i] = st.io_s[i];
            end
          end
          default:
          begin
            // Feedback shifts one pin outward; the outer slots hear the enable and clock pins
            if (i == macrocell_pkg::OUTER_CELL_OE)
            begin
              slot[i] = st.oe_n_s;
            end
            else if (i == macrocell_pkg::OUTER_CELL_CLK)
            begin
              slot[i] = st.clk_s;
            end
            else
            begin
              slot[i] = st.io_s[NEIGHBOUR];
            end
          end
        endcase
      end
    end
  endgenerate

  // Nineteen array inputs: eleven dedicated pins and eight feedback slots
  assign array_vec = {slot, st.in_s};

  // Each product term is an AND of selected literals, forced low when disabled
  generate
    for (genvar t = 0; t < macrocell_pkg::TERMS; t++)
    begin : g_term
      assign pterm[t] = st.term_en[t] && (&(array_vec | ~st.mask_true[t])) && (&(~array_vec | ~st.mask_comp[t]));
    end
    for (genvar c = 0; c < macrocell_pkg::CELLS; c++)
    begin : g_sum
      assign sum_full[c] = |pterm[c*macrocell_pkg::TERMS_PER_CELL +: 8];
      assign sum_io[c] = |pterm[c*macrocell_pkg::TERMS_PER_CELL + 1 +: 7];
      assign oe_term[c] = pterm[c*macrocell_pkg::TERMS_PER_CELL];
    end
  endgenerate

  // Next state: pin sampling, cell behaviour and the register slave
  always_comb
  begin
    next_st = st;
    next_st.pd_s = powerdown_pin;
    // Standby freezes samples, outputs and clocked cell register updates alike; a preload write still loads the cells
    if (!st.pd_s)
    begin
      next_st.in_s = data_in;
      next_st.io_s = io_in;
      next_st.clk_s = clk_or_in_pin;
      next_st.clk_prev = st.clk_s;
      next_st.oe_n_s = oe_n_or_in_pin;
      for (int c = 0; c < macrocell_pkg::CELLS; c++)
      begin
        case (mode)
          macrocell_pkg::MODE_REGISTERED:
          begin
            if (!st.cell_role_select_bit[c])
            begin
              if (clk_rise)
              begin
                next_st.cell_q[c] = st.polarity[c] ? sum_full[c] : ~sum_full[c];
              end
              next_st.out[c] = st.cell_q[c];
              next_st.oe[c] = !st.oe_n_s;
            end
            else
            begin
              next_st.out[c] = st.polarity[c] ? sum_io[c] : ~sum_io[c];
              next_st.oe[c] = oe_term[c];
            end
          end
          macrocell_pkg::MODE_COMPLEX:
          begin
            next_st.out[c] = st.polarity[c] ? sum_io[c] : ~sum_io[c];
            next_st.oe[c] = oe_term[c];
          end
          default:
          begin
            if (st.cell_role_select_bit[c] && c != macrocell_pkg::INNER_CELL_A && c != macrocell_pkg::INNER_CELL_B)
            begin
              next_st.out[c] = 1'b0;
              next_st.oe[c] = 1'b0;
            end
            else
            begin
              next_st.out[c] = st.polarity[c] ? sum_full[c] : ~sum_full[c];
              next_st.oe[c] = 1'b1;
            end
          end
        endcase
      end
    end
    // Write channel capture, in either order
    if (aw_go)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_go)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    // Perform the write once address and data are both held
    if (st.aw_held && st.w_held)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = macrocell_pkg::RESP_OKAY;
      case ({st.aw_addr[11:2], 2'b00})
        macrocell_pkg::ADDR_ARCH:
        begin
          if (st.w_strb[0])
          begin
            next_st.sync_mode_bit = st.w_data[macrocell_pkg::ARCH_SYNC_BIT];
            next_st.global_mode_ctrl_bit = st.w_data[macrocell_pkg::ARCH_CTRL_BIT];
          end
        end
        macrocell_pkg::ADDR_CELL_CFG:
        begin
          {next_st.cell_role_select_bit, next_st.polarity} =
            16'(merge({16'h0000, st.cell_role_select_bit, st.polarity}, st.w_data, st.w_strb));
        end
        macrocell_pkg::ADDR_TERM_EN_LO:
        begin
          next_st.term_en[31:0] = merge(st.term_en[31:0], st.w_data, st.w_strb);
        end
        macrocell_pkg::ADDR_TERM_EN_HI:
        begin
          next_st.term_en[63:32] = merge(st.term_en[63:32], st.w_data, st.w_strb);
        end
        macrocell_pkg::ADDR_SIG_LO:
        begin
          next_st.user_signature_area[31:0] = merge(st.user_signature_area[31:0], st.w_data, st.w_strb);
        end
        macrocell_pkg::ADDR_SIG_HI:
        begin
          next_st.user_signature_area[63:32] = merge(st.user_signature_area[63:32], st.w_data, st.w_strb);
        end
        macrocell_pkg::ADDR_PRELOAD:
        begin
          if (st.w_strb[0])
          begin
            next_st.cell_q = st.w_data[7:0];
          end
        end
        default:
        begin
          if (in_terms(st.aw_addr) && !toff_w[2])
          begin
            next_st.mask_true[toff_w[8:3]] = 19'(merge({13'h0000, st.mask_true[toff_w[8:3]]}, st.w_data, st.w_strb));
          end
          else if (in_terms(st.aw_addr))
          begin
            next_st.mask_comp[toff_w[8:3]] = 19'(merge({13'h0000, st.mask_comp[toff_w[8:3]]}, st.w_data, st.w_strb));
          end
          else
          begin
            next_st.bresp = (st.aw_addr == macrocell_pkg::ADDR_STATUS) ? macrocell_pkg::RESP_OKAY :
                            macrocell_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    // Read answer is registered on the same edge that takes the address
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (ar_go)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = macrocell_pkg::RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case ({s_axi_araddr[11:2], 2'b00})
        macrocell_pkg::ADDR_ARCH:
        begin
          next_st.rdata[macrocell_pkg::ARCH_SYNC_BIT] = st.sync_mode_bit;
          next_st.rdata[macrocell_pkg::ARCH_CTRL_BIT] = st.global_mode_ctrl_bit;
        end
        macrocell_pkg::ADDR_CELL_CFG:
        begin
          next_st.rdata[15:0] = {st.cell_role_select_bit, st.polarity};
        end
        macrocell_pkg::ADDR_TERM_EN_LO:
        begin
          next_st.rdata = st.term_en[31:0];
        end
        macrocell_pkg::ADDR_TERM_EN_HI:
        begin
          next_st.rdata = st.term_en[63:32];
        end
        macrocell_pkg::ADDR_SIG_LO:
        begin
          next_st.rdata = st.user_signature_area[31:0];
        end
        macrocell_pkg::ADDR_SIG_HI:
        begin
          next_st.rdata = st.user_signature_area[63:32];
        end
        macrocell_pkg::ADDR_PRELOAD:
        begin
          next_st.rdata[7:0] = st.cell_q;
        end
        macrocell_pkg::ADDR_STATUS:
        begin
          next_st.rdata[7:0] = st.out;
          next_st.rdata[macrocell_pkg::STATUS_PD_BIT] = st.pd_s;
          next_st.rdata[macrocell_pkg::STATUS_MODE_LSB +: 2] = mode;
        end
        default:
        begin
          if (in_terms(s_axi_araddr))
          begin
            next_st.rdata[18:0] = toff_r[2] ? st.mask_comp[toff_r[8:3]] : st.mask_true[toff_r[8:3]];
          end
          else
          begin
            next_st.rresp = macrocell_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // Single state register; clock enable low freezes everything, reset clears the cells
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= ST_RESET;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

endmodule

// file: tb/pin_partner.sv
// Surrounding logic model: resolves the macrocell pins and makes the shared register clock
`timescale 1ns/100ps
module pin_partner
(
  input wire logic aclk,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  input wire logic [7:0] ext,
  input wire logic tick,
  output logic [7:0] io_in,
  output logic clk_or_in_pin
);
  logic [2:0] phase = 3'h0;
  // A pin shows the cell's value while it drives, else the outside value
  assign io_in = (io_oe & io_out) | (~io_oe & ext);
  // One clock pulse per request, two cycles high, then idle low between pulses
  always @(posedge aclk)
  begin
    if (phase != 3'h0)
      phase <= phase - 3'h1;
    else if (tick)
      phase <= 3'h4;
  end
  assign clk_or_in_pin = phase > 3'h2;
endmodule

// file: tb/macrocell_checker.sv
// Concurrent checks on the macrocell array pins
`timescale 1ns/100ps
module macrocell_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clk_or_in_pin,
  input wire logic oe_n_or_in_pin,
  input wire logic powerdown_pin,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe
);
  logic [1:0] arch;
  logic [7:0] pol;
  logic [7:0] role;
  logic [7:0] keep;
  logic [3:0] stab;
  logic dirty;
  logic wr;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Inner cells always drive in simple mode
  assign keep = ~role | 8'h18;
  // Shadow of the setup; stab gives outputs time to settle after any write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arch <= 2'b01;
      pol <= 8'h00;
      role <= 8'h00;
      dirty <= 1'b0;
      stab <= 4'h0;
    end
    else
    begin
      stab <= wr ? 4'h0 : (stab == 4'hf ? stab : stab + 4'h1);
      if (wr && s_axi_awaddr == macrocell_pkg::ADDR_ARCH)
        arch <= s_axi_wdata[1:0];
      if (wr && s_axi_awaddr == macrocell_pkg::ADDR_CELL_CFG)
      begin
        pol <= s_axi_wdata[7:0];
        role <= s_axi_wdata[15:8];
      end
      // Any term edit makes the all-true term picture invalid
      if (wr && (s_axi_awaddr[11:3] == 9'h001 || |s_axi_awaddr[9:8]))
        dirty <= 1'b1;
    end
  end
  chk_reset_clear: assert property ($rose(aresetn) |-> io_out == 8'h00 && io_oe == 8'h00 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  chk_simple_oe: assert property (arch == 2'b01 && stab >= 4 |-> io_oe == keep)
    else $error("simple mode enables wrong");
  chk_simple_pol: assert property (arch == 2'b01 && !dirty && stab >= 4 |-> ((io_out ^ pol) & keep) == 8'h00)
    else $error("simple mode polarity wrong");
  chk_complex_out: assert property (arch == 2'b11 && !dirty && stab >= 4 |-> io_oe == 8'hff && io_out == pol)
    else $error("complex mode outputs wrong");
  chk_reg_io: assert property (arch == 2'b10 && !dirty && stab >= 4 |-> (io_oe & role) == role && ((io_out ^ pol) & role) == 8'h00)
    else $error("registered mode io cell wrong");
  chk_oe_float: assert property ((arch == 2'b10 && stab >= 4 && oe_n_or_in_pin)[*2] |=> (io_oe & ~role) == 8'h00)
    else $error("registered cell drives while disabled");
  chk_oe_drive: assert property ((arch == 2'b10 && stab >= 4 && !oe_n_or_in_pin)[*2] |=> (io_oe & ~role) == ~role)
    else $error("registered cell not driving while enabled");
  chk_reg_hold: assert property ((arch == 2'b10 && stab >= 4 && !clk_or_in_pin)[*3] |=> $stable(io_out & ~role))
    else $error("register changed without a clock rise");
  chk_pd_hold: assert property (powerdown_pin[*3] |=> $stable(io_out) && $stable(io_oe))
    else $error("outputs moved during standby");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (powerdown_pin && arch == 2'b10);
  cover property (arch == 2'b10 && $rose(clk_or_in_pin));
endmodule
bind output_macrocell_array macrocell_checker chk_inst
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .clk_or_in_pin, .oe_n_or_in_pin, .powerdown_pin, .io_out, .io_oe
);

// file: tb/tb_top.sv
// Self-checking bench: sets up the macrocell array over AXI4-Lite and watches its pins
`timescale 1ns/100ps
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clk_or_in_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [10:0] data_in = 11'h000;
  logic oe_n_or_in_pin = 1'b1, powerdown_pin = 1'b0, tick = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] io_in, io_out, io_oe, pol, role;
  logic [33:0] exp_q[$];
  int bad_count = 0, num_checks = 0, cycles = 0;
  output_macrocell_array uut
  (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_in, .clk_or_in_pin,
    .oe_n_or_in_pin, .powerdown_pin, .io_in, .io_out, .io_oe
  );
  pin_partner partner (.aclk, .io_out, .io_oe, .ext, .tick, .io_in, .clk_or_in_pin);
  always #2 aclk = ~aclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A hang is cut short well beyond the few hundred cycles the tests need
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Responses are compared at the negedge before the accepting edge
  always @(negedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check({s_axi_bresp, 32'h00000000}, exp_q.pop_front());
  end
  // Looks at ready at the negedge, so the handshake edge is the next rising one
  task automatic wait_hi(ref logic s);
    logic t;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = s === 1'b1;
      @(posedge aclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    exp_q.push_back({r, 32'h00000000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      ta = ta || s_axi_awready === 1'b1;
      tw = tw || s_axi_wready === 1'b1;
      @(posedge aclk);
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] want);
    exp_q.push_back(want);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [33:0] st(input logic [1:0] m, input logic p, input logic [7:0] o);
    return {2'h0, 21'h000000, m, p, o};
  endfunction
  // Lets outputs settle, then compares enables in full and values on masked cells
  task automatic pins(input logic [7:0] m, input logic [7:0] oe, input logic [7:0] o);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check({26'h0, io_oe}, {26'h0, oe});
    check({26'h0, io_out & m}, {26'h0, o & m});
    @(posedge aclk);
  endtask
  task automatic pulse();
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
  endtask
  initial
  begin
    void'($urandom(19922));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(macrocell_pkg::ADDR_ARCH, {2'h0, 32'h00000001});
    rd(macrocell_pkg::ADDR_TERM_EN_HI, {2'h0, macrocell_pkg::TERM_EN_RESET});
    rd(macrocell_pkg::ADDR_STATUS, st(2'h0, 1'b0, 8'h00));
    pins(8'hff, 8'hff, 8'h00);
    rd(12'h020, {macrocell_pkg::RESP_SLVERR, 32'h00000000});
    wr(12'h020, 32'h5a5a5a5a, macrocell_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int n = 0; n < 3; n++)
    begin
      pol = 8'($urandom);
      role = 8'($urandom);
      data_in <= 11'($urandom);
      ext <= 8'($urandom);
      wr(macrocell_pkg::ADDR_CELL_CFG, {16'h0000, role, pol}, macrocell_pkg::RESP_OKAY);
      pins(~role | 8'h18, ~role | 8'h18, pol);
    end
    $display("test simple done");
    wr(macrocell_pkg::ADDR_ARCH, 32'h00000003, macrocell_pkg::RESP_OKAY);
    pins(8'hff, 8'hff, pol);
    rd(macrocell_pkg::ADDR_STATUS, st(2'h1, 1'b0, pol));
    oe_n_or_in_pin <= 1'b0;
    wr(macrocell_pkg::ADDR_ARCH, 32'h00000002, macrocell_pkg::RESP_OKAY);
    wr(macrocell_pkg::ADDR_PRELOAD, {24'h000000, ~pol}, macrocell_pkg::RESP_OKAY);
    pins(8'hff, 8'hff, ~(pol ^ role));
    rd(macrocell_pkg::ADDR_STATUS, st(2'h2, 1'b0, ~(pol ^ role)));
    pulse();
    pins(8'hff, 8'hff, pol);
    oe_n_or_in_pin <= 1'b1;
    pins(8'hff, role, pol);
    oe_n_or_in_pin <= 1'b0;
    wr(macrocell_pkg::ADDR_TERM_EN_LO, 32'hffffff00, macrocell_pkg::RESP_OKAY);
    pulse();
    pins(8'hff, 8'hff ^ {7'h00, role[0]}, pol ^ 8'h01);
    $display("test registered done");
    powerdown_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(macrocell_pkg::ADDR_TERM_EN_LO, 32'hffffffff, macrocell_pkg::RESP_OKAY);
    pulse();
    pins(8'hff, 8'hff ^ {7'h00, role[0]}, pol ^ 8'h01);
    rd(macrocell_pkg::ADDR_STATUS, st(2'h2, 1'b1, pol ^ 8'h01));
    powerdown_pin <= 1'b0;
    pulse();
    pins(8'hff, 8'hff, pol);
    $display("test standby done");
    wr(macrocell_pkg::ADDR_ARCH, 32'h00000003, macrocell_pkg::RESP_OKAY);
    wr(macrocell_pkg::ADDR_TERM_EN_LO, 32'hff03ffff, macrocell_pkg::RESP_OKAY);
    wr(macrocell_pkg::ADDR_TERM_BASE + 12'h088, 32'h00000800, macrocell_pkg::RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      oe_n_or_in_pin <= v[0];
      pins(8'h04, 8'hff, {5'h00, ~(v[0] ^ pol[2]), 2'h0});
    end
    $display("test complex feedback done");
    wr(macrocell_pkg::ADDR_ARCH, 32'h00000001, macrocell_pkg::RESP_OKAY);
    wr(macrocell_pkg::ADDR_TERM_EN_LO, 32'h02ffffff, macrocell_pkg::RESP_OKAY);
    wr(macrocell_pkg::ADDR_TERM_BASE + 12'h0c8, 32'h00000800, macrocell_pkg::RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      oe_n_or_in_pin <= v[0];
      pins(8'h08, ~role | 8'h18, {4'h0, ~(v[0] ^ pol[3]), 3'h0});
    end
    $display("test simple feedback done");
    // Clock enable low must freeze the pins and close the bus
    ce <= 1'b0;
    oe_n_or_in_pin <= 1'b0;
    pins(8'h08, ~role | 8'h18, {4'h0, pol[3], 3'h0});
    @(negedge aclk);
    check({33'h0, s_axi_awready | s_axi_arready}, 34'h0);
    @(posedge aclk);
    ce <= 1'b1;
    $display("test clock enable done");
    print_verdict();
  end
endmodule
